/* rtl/mode_link_pkg.sv */
// Constants, types and the mode-word decoder shared by the mode-control link block
package mode_link_pkg;

   // ======================================================================
   // Word geometry
   localparam int MODE_W     = 24;        // Mode word width
   localparam int CTRL_W     = 32;        // Full control word width
   localparam int MODE_LSB   = 8;         // Mode word sits in the upper bits
   localparam int CHAN_N     = 4;         // Interpolator channels
   localparam int RESULT_W   = 24;        // Width of one returned value
   localparam int FIFO_DEPTH = 16;        // Returned-value buffer depth

   // ======================================================================
   // Mode word field positions (channel 0 at the highest bit of a group)
   localparam int START_BIT  = 23;
   localparam int SEL0_HI    = 22;
   localparam int SEL1_HI    = 18;
   localparam int SEL2_HI    = 14;
   localparam int HOLD_HI    = 10;
   localparam int CLEAR_HI   = 6;
   localparam int INVERT_BIT = 0;

   // ======================================================================
   // Low control bits and delay settings
   localparam int HDR_LSB     = 0;        // Header bit count field
   localparam int HDR_W       = 4;
   localparam int UTOS_BIT    = 4;        // Unsigned-to-signed conversion
   localparam int DELAY_W     = 8;        // Launch delay setting width
   localparam int DELAY_UNIT  = 16;       // Serial clock cycles per delay step
   localparam int DELAY_CNT_W = 12;       // Holds 255 * 16
   localparam int FRAME_CYCLES = 25;      // Serial clock cycles per transfer
   localparam int BIT_CNT_W   = 5;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 32'h0000_0000;

   // ======================================================================
   // Register map (byte addresses) and status fields
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] OFF_CTRL   = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_MODE   = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_DELAY  = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h0c;
   localparam logic [ADDR_W-1:0] OFF_RESULT = 5'h10;
   localparam int STAT_BUSY      = 0;
   localparam int STAT_VALID     = 1;
   localparam int STAT_OVERRUN   = 2;
   localparam int STAT_LEVEL_LSB = 8;

   // ======================================================================
   // Types
   typedef struct packed {
      logic [2:0] sel;                    // Additional-data selector
      logic       hold;                   // Freeze present corrections
      logic       clear;                  // Use uncorrected signals
   } chan_cfg_t;

   typedef struct packed {
      logic                    start;
      logic                    invert;
      chan_cfg_t [CHAN_N-1:0]  chan;
   } mode_cfg_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_DELAY = 4'h2,
      ST_SHIFT = 4'h4,
      ST_PUSH  = 4'h8
   } link_state_t;

   // ======================================================================
   // Splits a mode word into per-channel settings; bits 2 and 1 are unused
   function automatic mode_cfg_t decode_mode(input logic [MODE_W-1:0] w);
      mode_cfg_t m;
      m.start  = w[START_BIT];
      m.invert = w[INVERT_BIT];
      for (int j = 0; j < CHAN_N; j++) begin
         m.chan[j].sel   = {w[SEL2_HI-j], w[SEL1_HI-j], w[SEL0_HI-j]};
         m.chan[j].hold  = w[HOLD_HI-j];
         m.chan[j].clear = w[CLEAR_HI-j];
      end
      return m;
   endfunction

endpackage

/* rtl/result_fifo.sv */
// Synchronous FIFO buffering returned serial values for software
`timescale 1ns/10ps
module result_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   input  wire logic                     clk_i,
   input  wire logic                     rstn_i,
   input  wire logic                     in_valid_i,
   output logic                          in_ready_o,
   input  wire logic [WIDTH-1:0]         in_data_i,
   output logic                          out_valid_o,
   input  wire logic                     out_ready_i,
   output logic [WIDTH-1:0]              out_data_o,
   output logic [$clog2(DEPTH):0]        level_o
);

   localparam int PW = $clog2(DEPTH);

   // ======================================================================
   // Parameter check
   initial begin
      if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin
         $error("result_fifo: DEPTH must be a power of two of at least 2");
      end
   end

   // ======================================================================
   // Storage and pointers; the extra pointer bit tells full from empty
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW:0]      wr_ptr;
   logic [PW:0]      rd_ptr;
   logic             push;
   logic             pop;

   assign level_o     = wr_ptr - rd_ptr;
   assign in_ready_o  = (level_o != (PW+1)'(DEPTH));
   assign out_valid_o = (wr_ptr != rd_ptr);
   assign out_data_o  = mem[rd_ptr[PW-1:0]];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // Write side
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_ptr <= '0;
      end else if (push) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end

   // Memory has no reset; only written entries are ever read
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr[PW-1:0]] <= in_data_i;
      end
   end

   // Read side
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_ptr <= '0;
      end else if (pop) begin
         rd_ptr <= rd_ptr + 1'b1;
      end
   end

endmodule

/* rtl/mode_control_link.sv */
// Mode-control serial link: sends the mode word each phase cycle, collects the returned value
//
// What this block does
// - Each phase cycle shift the 24-bit mode word out MSB first, one bit per clock.
// - Bit 23 must be 1; conversions start only when it arrives as 1.
// - Start bit goes first and launches the return transfer from the far end.
// - Only bit 23 set means standard operation with all corrections active.
// - Per-channel 3-bit selector taken from bit groups 22-19, 18-15, 14-11.
// - Bits 6 to 3 clear corrections for channels 0 to 3.
// - Bits 10 to 7 hold present corrections for channels 0 to 3.
// - Bit 0 selects inversion of the serial clock for all channels.
// - Selector 0 returns raw sine and cosine readings each phase cycle.
// - Selector 1 returns unfiltered corrected sine and cosine each phase cycle.
// - Selector 2 bias, 3 mismatch and phase, 4 to 7 velocity scalings.
// - Mode word is the upper 24 bits of the 32-bit control word.
// - Returned data has no header bits; header count must be zero.
// - One complete serial transfer takes 25 serial clock cycles.
// - Launch delay counts in steps of 16 serial clocks after phase edge.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module mode_control_link
   import mode_link_pkg::*;
#(
   parameter int BUF_DEPTH = FIFO_DEPTH
) (
   input  wire logic                REF_CLK_I,
   input  wire logic                RESETN_I,
   input  wire logic [ADDR_W-1:0]   REG_ADDR_I,
   input  wire logic [CTRL_W-1:0]   REG_WDATA_I,
   input  wire logic                REG_WR_I,
   input  wire logic                REG_RD_I,
   output logic      [CTRL_W-1:0]   REG_RDATA_O,
   input  wire logic                PHASE_CLK_I,
   input  wire logic                SER_CLK_I,
   input  wire logic                SER_DATA_I,
   output logic                     SER_DATA_O,
   output logic                     CONVERT_START_O,
   output mode_cfg_t                MODE_O
);

   localparam int LVL_W = $clog2(BUF_DEPTH) + 1;
   localparam logic [BIT_CNT_W-1:0] BIT_LAST = BIT_CNT_W'(FRAME_CYCLES - 1);

   // ======================================================================
   // Parameter check
   initial begin
      if (BUF_DEPTH < 2 || STAT_LEVEL_LSB + LVL_W > CTRL_W) begin
         $error("mode_control_link: BUF_DEPTH out of range");
      end
   end

   // ======================================================================
   // Input synchronisers; only the second stage feeds any logic
   logic [1:0] phase_sync;
   logic [1:0] sclk_sync;
   logic [1:0] din_sync;
   logic       phase_last;
   logic       sclk_last;

   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         phase_sync <= 2'h0;
         sclk_sync  <= 2'h0;
         din_sync   <= 2'h0;
         phase_last <= 1'b0;
         sclk_last  <= 1'b0;
      end else begin
         phase_sync <= {phase_sync[0], PHASE_CLK_I};
         sclk_sync  <= {sclk_sync[0], SER_CLK_I};
         din_sync   <= {din_sync[0], SER_DATA_I};
         phase_last <= phase_sync[1];
         sclk_last  <= sclk_sync[1];
      end
   end

   // ======================================================================
   // Registers
   logic [CTRL_W-1:0]  ctrl_word;
   logic [DELAY_W-1:0] launch_delay;
   logic               overrun;

   // Edge choice follows the live invert bit, so a change takes hold at once
   logic phase_rise;
   logic sclk_rise;
   logic sclk_fall;
   logic launch_edge;
   logic sample_edge;

   assign phase_rise  = phase_sync[1] & ~phase_last;
   assign sclk_rise   = sclk_sync[1] & ~sclk_last;
   assign sclk_fall   = ~sclk_sync[1] & sclk_last;
   assign launch_edge = ctrl_word[MODE_LSB + INVERT_BIT] ? sclk_rise : sclk_fall;
   assign sample_edge = ctrl_word[MODE_LSB + INVERT_BIT] ? sclk_fall : sclk_rise;

   logic wr_ctrl;
   logic wr_mode;
   logic wr_delay;
   logic wr_status;
   logic rd_result;

   assign wr_ctrl   = REG_WR_I && (REG_ADDR_I == OFF_CTRL);
   assign wr_mode   = REG_WR_I && (REG_ADDR_I == OFF_MODE);
   assign wr_delay  = REG_WR_I && (REG_ADDR_I == OFF_DELAY);
   assign wr_status = REG_WR_I && (REG_ADDR_I == OFF_STATUS);
   assign rd_result = REG_RD_I && (REG_ADDR_I == OFF_RESULT);

   // Control word; the mode register is a window on its upper 24 bits
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ctrl_word <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_word <= REG_WDATA_I;
      end else if (wr_mode) begin
         ctrl_word[CTRL_W-1:MODE_LSB] <= REG_WDATA_I[MODE_W-1:0];
      end
   end

   // Launch delay setting
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         launch_delay <= '0;
      end else if (wr_delay) begin
         launch_delay <= REG_WDATA_I[DELAY_W-1:0];
      end
   end

   // ======================================================================
   // Frame sequencer
   link_state_t            state;
   logic [MODE_W-1:0]      mode_shadow;
   logic [MODE_W-1:0]      tx_sr;
   logic [RESULT_W-1:0]    rx_sr;
   logic [HDR_W-1:0]       hdr_shadow;
   logic                   utos_shadow;
   logic [BIT_CNT_W-1:0]   bit_cnt;
   logic [DELAY_CNT_W-1:0] delay_cnt;
   logic [DELAY_CNT_W-1:0] delay_target;
   logic                   fifo_in_valid;
   logic                   fifo_in_ready;
   logic [RESULT_W-1:0]    fifo_in_data;
   logic [RESULT_W-1:0]    shifted;

   assign delay_target = DELAY_CNT_W'(launch_delay * DELAY_UNIT);

   // State transitions; a word the buffer refuses holds the frame in PUSH
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (phase_rise) begin
                  state <= (delay_target == '0) ? ST_SHIFT : ST_DELAY;
               end
            end
            ST_DELAY: begin
               if (launch_edge && (delay_cnt + 1'b1 == delay_target)) begin
                  state <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (sample_edge && bit_cnt == BIT_LAST) begin
                  state <= ST_PUSH;
               end
            end
            ST_PUSH: begin
               if (!mode_shadow[START_BIT] || fifo_in_ready) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Settings captured at the phase edge so software may write mid-frame
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         mode_shadow <= '0;
         hdr_shadow  <= '0;
         utos_shadow <= 1'b0;
      end else if (state == ST_IDLE && phase_rise) begin
         mode_shadow <= ctrl_word[CTRL_W-1:MODE_LSB];
         hdr_shadow  <= ctrl_word[HDR_LSB +: HDR_W];
         utos_shadow <= ctrl_word[UTOS_BIT];
      end
   end

   // Delay counter in launch edges of the serial clock
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         delay_cnt <= '0;
      end else if (state != ST_DELAY) begin
         delay_cnt <= '0;
      end else if (launch_edge) begin
         delay_cnt <= delay_cnt + 1'b1;
      end
   end

   // Transmit shift register, start bit first; zeros shift in behind
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         tx_sr   <= '0;
         bit_cnt <= '0;
      end else if (state != ST_SHIFT) begin
         tx_sr   <= (state == ST_IDLE && phase_rise && delay_target == '0) ?
                    ctrl_word[CTRL_W-1:MODE_LSB] : mode_shadow;
         bit_cnt <= '0;
      end else if (launch_edge && bit_cnt != BIT_LAST) begin
         tx_sr   <= {tx_sr[MODE_W-2:0], 1'b0};
         bit_cnt <= bit_cnt + 1'b1;
      end
   end

   assign SER_DATA_O = (state == ST_SHIFT) ? tx_sr[MODE_W-1] : 1'b0;

   // Receive: bits in the 24 cycles after the start bit
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rx_sr <= '0;
      end else if (state == ST_SHIFT && sample_edge && bit_cnt != '0) begin
         rx_sr <= {rx_sr[RESULT_W-2:0], din_sync[1]};
      end
   end

   // Leading header bits are dropped; zero is the only correct setting here
   assign shifted       = RESULT_W'(rx_sr << hdr_shadow);
   assign fifo_in_data  = {shifted[RESULT_W-1] ^ utos_shadow, shifted[RESULT_W-2:0]};
   assign fifo_in_valid = (state == ST_PUSH) && mode_shadow[START_BIT];

   // Conversion start pulse when a frame with the start bit launches
   logic next_shift_entry;
   logic next_start;
   assign next_shift_entry = (state == ST_IDLE && phase_rise && delay_target == '0) ||
                             (state == ST_DELAY && launch_edge && delay_cnt + 1'b1 == delay_target);
   assign next_start       = (state == ST_IDLE) ? ctrl_word[CTRL_W-1] : mode_shadow[START_BIT];

   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         CONVERT_START_O <= 1'b0;
      end else begin
         CONVERT_START_O <= (state != ST_SHIFT) && (next_shift_entry) && next_start;
      end
   end

   // Decoded settings change only as the frame leaves PUSH, once its returned value is taken if it has a start bit
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         MODE_O <= '0;
      end else if (state == ST_PUSH && (!mode_shadow[START_BIT] || fifo_in_ready)) begin
         MODE_O <= decode_mode(mode_shadow);
      end
   end

   // Phase edge missed while a frame is still busy; the set wins over a clear
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         overrun <= 1'b0;
      end else if (phase_rise && state != ST_IDLE) begin
         overrun <= 1'b1;
      end else if (wr_status && REG_WDATA_I[STAT_OVERRUN]) begin
         overrun <= 1'b0;
      end
   end

   // ======================================================================
   // Returned-value buffer, drained by reads of the result register
   logic                fifo_out_valid;
   logic [RESULT_W-1:0] fifo_out_data;
   logic [LVL_W-1:0]    fifo_level;

   result_fifo #(
      .WIDTH (RESULT_W),
      .DEPTH (BUF_DEPTH)
   ) u_fifo (
      .clk_i       (REF_CLK_I),
      .rstn_i      (RESETN_I),
      .in_valid_i  (fifo_in_valid),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (fifo_in_data),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (rd_result),
      .out_data_o  (fifo_out_data),
      .level_o     (fifo_level)
   );

   // ======================================================================
   // Read port: data stand one cycle after the strobe, zero when unmapped
   logic [CTRL_W-1:0] status_word;

   always_comb begin
      status_word                                 = '0;
      status_word[STAT_BUSY]                      = (state != ST_IDLE);
      status_word[STAT_VALID]                     = fifo_out_valid;
      status_word[STAT_OVERRUN]                   = overrun;
      status_word[STAT_LEVEL_LSB +: LVL_W]        = fifo_level;
   end

   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         REG_RDATA_O <= '0;
      end else if (REG_RD_I) begin
         unique case (REG_ADDR_I)
            OFF_CTRL:   REG_RDATA_O <= ctrl_word;
            OFF_MODE:   REG_RDATA_O <= CTRL_W'(ctrl_word[CTRL_W-1:MODE_LSB]);
            OFF_DELAY:  REG_RDATA_O <= CTRL_W'(launch_delay);
            OFF_STATUS: REG_RDATA_O <= status_word;
            OFF_RESULT: REG_RDATA_O <= fifo_out_valid ? CTRL_W'(fifo_out_data) : '0;
            default:    REG_RDATA_O <= '0;
         endcase
      end else begin
         REG_RDATA_O <= '0;
      end
   end

   // ======================================================================
   // Assertions
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RESETN_I);

   frame_length_a: assert property (state == ST_SHIFT |-> bit_cnt <= BIT_LAST)
      else $error("serial transfer longer than its cycle count");
   msb_first_a: assert property ($rose(state == ST_SHIFT) |-> SER_DATA_O == mode_shadow[START_BIT])
      else $error("first serial bit is not the start bit");
   start_pulse_a: assert property (CONVERT_START_O |-> state == ST_SHIFT && mode_shadow[START_BIT])
      else $error("conversion start without start bit");
   mode_apply_a: assert property (!$stable(MODE_O) |-> $past(state) == ST_PUSH)
      else $error("mode settings changed before the frame ended");
   decode_fields_a: assert property ($past(state) == ST_PUSH && state == ST_IDLE
                                     |-> MODE_O == decode_mode($past(mode_shadow)))
      else $error("decoded mode settings do not match the word");
   standard_mode_a: assert property ($past(state) == ST_PUSH && state == ST_IDLE &&
                                     $past(mode_shadow) == 24'h80_0000 |-> MODE_O.chan == '0)
      else $error("standard word left a channel option set");
   delay_bound_a: assert property (state == ST_DELAY |-> delay_cnt < delay_target)
      else $error("launch delay overran its setting");
   return_only_a: assert property (fifo_in_valid |-> mode_shadow[START_BIT] && $past(state) != ST_IDLE)
      else $error("returned value taken without a start bit");
   no_header_a: assert property (fifo_in_valid && hdr_shadow == '0 && !utos_shadow
                                 |-> fifo_in_data == rx_sr)
      else $error("returned value altered with zero header bits");
   stall_hold_a: assert property (fifo_in_valid && !fifo_in_ready |=> state == ST_PUSH)
      else $error("refused value was dropped");

   delayed_frame_c: cover property ($rose(state == ST_DELAY) ##[1:1000] $rose(state == ST_SHIFT));
   overrun_c:       cover property ($rose(overrun));
   buffer_full_c:   cover property (fifo_in_valid && !fifo_in_ready);
   inverted_c:      cover property (ctrl_word[MODE_LSB + INVERT_BIT] && $rose(state == ST_PUSH));

endmodule

/* tb/interp_far_end.sv */
// Behavioural far-end interpolator answering the mode-control serial link
`timescale 1ns/10ps
module interp_far_end (
   input  wire logic        ser_clk_i,
   input  wire logic        inv_i,
   input  wire logic        mode_i,
   input  wire logic [23:0] ret_i,
   output logic             ret_o,
   output logic [23:0]      word_o,
   output int               frames_o
);
   logic act = 1'b0;
   int   falls;
   // ======================================================================
   // Frame handling
   // Any rise of the data line while idle opens a frame; the answer then leads with its MSB
   always @(posedge mode_i) begin
      if (!act) begin
         act = 1'b1;
         falls = 0;
         ret_o = ret_i[23];
      end
   end
   // Launch edge: take the bit still shown, then show the answer bit that the
   // block samples in this serial cycle (MSB in cycle 1); a released line toggles
   always @(negedge (ser_clk_i ^ inv_i)) begin
      if (act) begin
         word_o = {word_o[22:0], mode_i};
         falls++;
         ret_o = ret_i[24-falls];
         act = (falls < 24);
         frames_o = act ? frames_o : frames_o + 1;
      end else begin
         ret_o = ~ret_o;
      end
   end
   initial begin
      ret_o = 1'b0;
      word_o = '0;
      frames_o = 0;
   end
endmodule

/* tb/mode_control_link_tb.sv */
// Self-checking bench for the mode-control serial link
`timescale 1ns/10ps
module mode_control_link_tb;
   import mode_link_pkg::*;
   localparam int DEPTH = 4;
   logic              clk, rstn, wr, rd, phase, ser_clk, inv, sdi, sdo, conv;
   logic [ADDR_W-1:0] addr;
   logic [CTRL_W-1:0] wdata, rdata, got;
   mode_cfg_t         mode, em, prev;
   logic [23:0]       ret, w, word;
   int                num_errors = 0;
   int                samples_checked = 0;
   int                convs = 0;
   int                frames, ch, n;

   // ======================================================================
   // Design and far end
   mode_control_link #(.BUF_DEPTH(DEPTH)) mode_control_link_i (.REF_CLK_I(clk), .RESETN_I(rstn),
      .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
      .PHASE_CLK_I(phase), .SER_CLK_I(ser_clk), .SER_DATA_I(sdi), .SER_DATA_O(sdo),
      .CONVERT_START_O(conv), .MODE_O(mode));
   interp_far_end interp_far_end_i (.ser_clk_i(ser_clk), .inv_i(inv), .mode_i(sdo), .ret_i(ret),
      .ret_o(sdi), .word_o(word), .frames_o(frames));

   // ======================================================================
   // Clocks; the serial clock is offset so its edges never coincide with core clock edges
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      ser_clk = 1'b0;
      #13;
      forever #40 ser_clk = ~ser_clk;
   end
   // Start pulses last one cycle; count them mid-cycle where they are settled
   always @(negedge clk) if (conv === 1'b1) convs++;

   // ======================================================================
   // Tasks
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 got = rdata;
      chk(what, exp, got);
   endtask
   // Phase edge placed just after a launch edge, so each frame starts in the same serial phase
   task automatic pulse_phase();
      @(negedge (ser_clk ^ inv));
      @(posedge clk);
      phase <= 1'b1;
      repeat (8) @(posedge clk);
      phase <= 1'b0;
   endtask
   task automatic frame(input bit far, input bit dly);
      int k;
      int nf;
      k = 0;
      nf = frames;
      pulse_phase();
      if (dly) begin
         #1101 chk("launch delay", 32'h0, {31'h0, sdo});
      end
      while (far && frames == nf && k < 3000) begin
         @(posedge clk);
         k++;
      end
      if (k == 3000) begin
         $display("Error frame expected done seen timeout");
         num_errors++;
         summarize();
      end
      // A frame lasts 25 serial cycles, 2000 ns
      repeat (far ? 40 : 700) @(posedge clk);
   endtask

   // ======================================================================
   // Main sequence
   initial begin
      rstn = 1'b0;
      {wr, rd, phase, inv} = 4'h0;
      addr = '0;
      wdata = '0;
      ret = '0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      rd_chk("ctrl reset", OFF_CTRL, 32'h0);
      chk("mode reset", 32'h0, 32'(mode));
      wr_reg(OFF_CTRL, 32'h8000_0000);
      rd_chk("mode field", OFF_MODE, 32'h0080_0000);
      ret = 24'h5a3c96;
      frame(1'b1, 1'b0);
      chk("far word", 32'h0080_0000, {8'h00, word});
      rd_chk("result", OFF_RESULT, {8'h00, ret});
      em = '0;
      em.start = 1'b1;
      chk("standard mode", 32'(em), 32'(mode));
      prev = em;
      // Every selector code, with hold, clear, unused bits and inversion mixed in
      for (int v = 0; v < 8; v++) begin
         ch = v % 4;
         w = 24'h80_0000;
         {w[SEL2_HI-ch], w[SEL1_HI-ch], w[SEL0_HI-ch]} = v[2:0];
         w[HOLD_HI-ch] = v[0];
         w[CLEAR_HI-ch] = v[1];
         w[2:1] = (v == 6) ? 2'b11 : 2'b00;
         w[INVERT_BIT] = (v == 5);
         em = '0;
         em.start = 1'b1;
         em.invert = w[0];
         em.chan[ch] = {v[2:0], v[0], v[1]};
         ret = {8'hc3, 8'(v), 8'h5a};
         n = convs;
         wr_reg(OFF_MODE, {8'h00, w});
         inv <= w[0];
         chk("mode held", 32'(prev), 32'(mode));
         frame(1'b1, 1'b0);
         chk("far word", {8'h00, w}, {8'h00, word});
         chk("start pulse", 32'(n + 1), 32'(convs));
         chk("mode applied", 32'(em), 32'(mode));
         rd_chk("result", OFF_RESULT, {8'h00, ret});
         prev = em;
      end
      // Without the start bit nothing converts and nothing comes back
      n = convs;
      wr_reg(OFF_MODE, 32'h0);
      frame(1'b0, 1'b0);
      chk("no start pulse", 32'(n), 32'(convs));
      rd_chk("no result", OFF_STATUS, 32'h0);
      chk("mode no start", 32'h0, 32'(mode));
      wr_reg(OFF_DELAY, 32'h1);
      wr_reg(OFF_MODE, 32'h80_0000);
      frame(1'b1, 1'b1);
      rd_chk("delayed result", OFF_RESULT, {8'h00, ret});
      wr_reg(OFF_DELAY, 32'h0);
      // Fill the buffer; the last frame stalls, so a further phase edge is an overrun
      for (int f = 0; f <= DEPTH; f++) begin
         ret = {16'ha5c3, 8'(f)};
         frame(1'b1, 1'b0);
      end
      rd_chk("fifo full", OFF_STATUS, 32'h0000_0403);
      pulse_phase();
      repeat (20) @(posedge clk);
      rd_chk("overrun", OFF_STATUS, 32'h0000_0407);
      for (int f = 0; f <= DEPTH; f++) rd_chk("drained", OFF_RESULT, {16'h00a5, 8'hc3, 8'(f)});
      rd_chk("empty read", OFF_RESULT, 32'h0);
      wr_reg(OFF_STATUS, 32'h4);
      rd_chk("overrun cleared", OFF_STATUS, 32'h0);
      wr_reg(5'h18, 32'hffff_ffff);
      rd_chk("unmapped", 5'h14, 32'h0);
      rd_chk("ctrl kept", OFF_CTRL, 32'h8000_0000);
      summarize();
   end
endmodule
